/* File: logic/quad_dac_pkg.sv */
// Shared constants and types of the quad DAC serial update logic.
// Assumes one serial slave port and four 10-bit output channels.
package quad_dac_pkg;

    // ****************************************
    // Serial protocol constants
    // ****************************************
    localparam logic [4:0] ADDR_PREFIX = 5'h13;
    localparam logic [7:0] BCAST_ADDR = 8'h90;
    localparam logic [4:0] HS_CODE = 5'h01;
    localparam logic [3:0] ACK_BIT = 4'h8;
    localparam logic [3:0] FIRST_BIT = 4'h1;
    localparam logic [3:0] LAST_DATA_BIT = 4'h7;

    // ****************************************
    // Control byte fields
    // ****************************************
    localparam int CTL_EXT_HI = 7;
    localparam int CTL_EXT_LO = 6;
    localparam int CTL_MODE_HI = 5;
    localparam int CTL_MODE_LO = 4;
    localparam int CTL_SEL_HI = 2;
    localparam int CTL_SEL_LO = 1;
    localparam int CTL_PD = 0;
    localparam logic [1:0] LOAD_TEMP = 2'h0;
    localparam logic [1:0] LOAD_ONE = 2'h1;
    localparam logic [1:0] LOAD_SYNC = 2'h2;
    localparam logic [1:0] LOAD_ALL = 2'h3;

    // ****************************************
    // Register widths, resets and readback
    // ****************************************
    localparam int NUM_CH = 4;
    localparam logic [9:0] WORD_RST = 10'h000;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [5:0] PD_FILL = 6'h3f;
    localparam logic [1:0] RD_LAST_PD = 2'h2;
    localparam logic [1:0] RD_LAST_DATA = 2'h1;
    localparam logic [3:0] MASK_NONE = 4'h0;
    localparam logic [3:0] MASK_ALL = 4'hf;

    typedef enum logic [2:0] {
        PH_IDLE, PH_ADDR, PH_CTRL, PH_HIGH, PH_LOW, PH_READ
    } phase_e;

    // One update handed from the serial side to the output side
    typedef struct packed {
        logic [3:0] wr;
        logic [3:0] ld;
        logic [9:0] word;
    } upd_s;

    typedef struct packed {
        logic [1:0] ext;
        logic [1:0] dev;
    } pins_s;

endpackage

/* File: logic/quad_dac_update.sv */
// Serial slave, command decode and double-buffered registers of a quad DAC.
// Assumes SCL is a clock port that stops between frames; SDA is open drain.
//
// How it works
// - Every accepted byte is acknowledged by holding SDA low in ninth clock.
// - Update fires at the falling edge ending the ack after the low byte.
// - Control byte is kept; each further byte pair updates again.
// - Conversion bits come from the high byte; the low byte is ignored.
// - In high-speed mode later updates take 18 SCL cycles each.
// - A stop releases the bus; traffic is ignored until the next start.
// - First byte after start is address: 10011, two select bits, direction.
// - Device select pins are latched once after power-up.
// - Broadcast address is acknowledged whatever the select pins say.
// - Broadcast address is accepted for writes only.
// - Control byte layout; extended bits must match pins unless broadcast.
// - Load mode 00 writes only the selected staging register.
// - Load mode 01 writes staging and output of the selected channel.
// - Load mode 11: select high bit picks staging copy or new data, all.
// - Power-down flag set: top two high-byte bits carry power-down code.
// - Each channel has 10-bit staging and output words, power-down on top.
// - Rising load strobe copies all staging words to the outputs.
// - Readback store clears to zero at reset.
// - High-speed master code is not acknowledged and enables high speed.
// - Read with power-down flag set returns power-down, high, low bytes.
// - Read with power-down flag clear returns high then low byte.
`timescale 1ns/10ps
module quad_dac_update
    import quad_dac_pkg::*;
(
    // Clocks and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // Serial bus
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_o,
    output logic o_sda_oe,
    output logic o_hs_mode,
    // Straps and load strobe
    input wire logic i_dev_select_hi,
    input wire logic i_dev_select_lo,
    input wire logic i_ext_select_hi,
    input wire logic i_ext_select_lo,
    input wire logic i_ext_load_strobe,
    // Channel words to the output stage
    output logic [9:0] o_out_ch_a,
    output logic [9:0] o_out_ch_b,
    output logic [9:0] o_out_ch_c,
    output logic [9:0] o_out_ch_d
);

    // ****************************************
    // Functions
    // ****************************************
    function automatic upd_s make_upd(input logic [7:0] ctl, input logic [7:0] hi);
        logic [3:0] oh;
        upd_s u;
        oh = 4'h1 << ctl[CTL_SEL_HI:CTL_SEL_LO];
        u.word = ctl[CTL_PD] ? {hi[7:6], 8'h00} : {2'h0, hi};
        unique case (ctl[CTL_MODE_HI:CTL_MODE_LO])
            LOAD_TEMP: begin
                u.wr = oh;
                u.ld = MASK_NONE;
            end
            LOAD_ONE: begin
                u.wr = oh;
                u.ld = oh;
            end
            LOAD_SYNC: begin
                u.wr = oh;
                u.ld = MASK_ALL;
            end
            LOAD_ALL: begin
                u.wr = ctl[CTL_SEL_HI] ? MASK_ALL : MASK_NONE;
                u.ld = MASK_ALL;
            end
        endcase
        return u;
    endfunction

    function automatic logic [7:0] rd_byte(input logic [1:0] idx, input logic pd,
                                           input logic [9:0] w);
        logic [7:0] b;
        b = BYTE_RST;
        if (pd) begin
            if (idx == 2'h0) begin
                b = {w[9:8], PD_FILL};
            end else if (idx == 2'h1) begin
                b = w[7:0];
            end
        end else if (idx == 2'h0) begin
            b = w[7:0];
        end
        return b;
    endfunction

    // ****************************************
    // Start and stop detection
    // ****************************************
    // SDA edges while SCL is high; toggles are read on the next SCL rise
    logic start_tgl_q;
    logic stop_tgl_q;

    always_ff @(negedge i_sda or posedge i_rst) begin
        if (i_rst) begin
            start_tgl_q <= 1'b0;
        end else if (i_scl) begin
            start_tgl_q <= ~start_tgl_q;
        end
    end

    always_ff @(posedge i_sda or posedge i_rst) begin
        if (i_rst) begin
            stop_tgl_q <= 1'b0;
        end else if (i_scl) begin
            stop_tgl_q <= ~stop_tgl_q;
        end
    end

    // ****************************************
    // Bit sampling on the rising SCL edge
    // ****************************************
    logic start_seen_q;
    logic stop_seen_q;
    logic st_q;
    logic sp_q;
    logic nack_q;
    logic [3:0] cnt_q;
    logic [7:0] sh_q;
    phase_e phase_q;

    always_ff @(posedge i_scl or posedge i_rst) begin
        if (i_rst) begin
            start_seen_q <= 1'b0;
            stop_seen_q <= 1'b0;
            st_q <= 1'b0;
            sp_q <= 1'b0;
            nack_q <= 1'b0;
            cnt_q <= 4'h0;
            sh_q <= BYTE_RST;
        end else begin
            start_seen_q <= start_tgl_q;
            stop_seen_q <= stop_tgl_q;
            st_q <= start_tgl_q != start_seen_q;
            sp_q <= stop_tgl_q != stop_seen_q;
            if (start_tgl_q != start_seen_q) begin
                cnt_q <= FIRST_BIT;
                sh_q <= {sh_q[6:0], i_sda};
            end else if (phase_q != PH_IDLE) begin
                if (cnt_q == ACK_BIT) begin
                    cnt_q <= 4'h0;
                    nack_q <= i_sda;
                end else begin
                    cnt_q <= cnt_q + 4'h1;
                    sh_q <= {sh_q[6:0], i_sda};
                end
            end
        end
    end

    // ****************************************
    // Strap capture
    // ****************************************
    // Straps are caught a few edges after reset release, not under reset
    pins_s pins_meta_q;
    pins_s pins_sync_q;
    logic [1:0] warm_q;
    logic locked_q;
    logic [1:0] dev_q;

    always_ff @(posedge i_scl or posedge i_rst) begin
        if (i_rst) begin
            pins_meta_q <= '0;
            pins_sync_q <= '0;
            warm_q <= 2'h0;
            locked_q <= 1'b0;
            dev_q <= 2'h0;
        end else begin
            pins_meta_q <= {i_ext_select_hi, i_ext_select_lo, i_dev_select_hi, i_dev_select_lo};
            pins_sync_q <= pins_meta_q;
            warm_q <= {warm_q[0], 1'b1};
            if (warm_q[1] && !locked_q) begin
                dev_q <= pins_sync_q.dev;
                locked_q <= 1'b1;
            end
        end
    end

    // ****************************************
    // Byte handling on the falling SCL edge
    // ****************************************
    logic sda_oe_q;
    logic hs_q;
    logic bcast_q;
    logic pend_q;
    logic req_tgl_q;
    logic [1:0] rd_idx_q;
    logic [7:0] ctrl_q;
    logic [7:0] msb_q;
    logic [9:0] rb_q [NUM_CH];
    upd_s pay_q;
    logic own_addr;
    logic ext_hit;
    logic [9:0] rb_word;
    logic [7:0] tx_byte;
    logic [2:0] bit_idx;
    logic [1:0] rd_last;
    upd_s upd_new;

    assign own_addr = sh_q[7:3] == ADDR_PREFIX && sh_q[2:1] == dev_q;
    assign ext_hit = bcast_q || ctrl_q[CTL_EXT_HI:CTL_EXT_LO] == pins_sync_q.ext;
    assign rb_word = rb_q[ctrl_q[CTL_SEL_HI:CTL_SEL_LO]];
    assign tx_byte = rd_byte(rd_idx_q, ctrl_q[CTL_PD], rb_word);
    assign bit_idx = 3'(LAST_DATA_BIT - cnt_q);
    assign rd_last = ctrl_q[CTL_PD] ? RD_LAST_PD : RD_LAST_DATA;
    assign upd_new = make_upd(ctrl_q, msb_q);

    always_ff @(negedge i_scl or posedge i_rst) begin
        if (i_rst) begin
            phase_q <= PH_IDLE;
            sda_oe_q <= 1'b0;
            hs_q <= 1'b0;
            bcast_q <= 1'b0;
            pend_q <= 1'b0;
            req_tgl_q <= 1'b0;
            rd_idx_q <= 2'h0;
            ctrl_q <= BYTE_RST;
            msb_q <= BYTE_RST;
            pay_q <= '0;
            for (int i = 0; i < NUM_CH; i++) begin
                rb_q[i] <= WORD_RST;
            end
        end else if (st_q) begin
            phase_q <= PH_ADDR;
            sda_oe_q <= 1'b0;
            pend_q <= 1'b0;
            if (sp_q) begin
                hs_q <= 1'b0;
            end
        end else if (sp_q) begin
            phase_q <= PH_IDLE;
            sda_oe_q <= 1'b0;
            hs_q <= 1'b0;
        end else if (phase_q != PH_IDLE) begin
            if (cnt_q == ACK_BIT) begin
                unique case (phase_q)
                    PH_ADDR: begin
                        if (sh_q[7:3] == HS_CODE) begin
                            hs_q <= 1'b1;
                            phase_q <= PH_IDLE;
                        end else if (own_addr && !sh_q[0]) begin
                            sda_oe_q <= 1'b1;
                            bcast_q <= 1'b0;
                            phase_q <= PH_CTRL;
                        end else if (sh_q == BCAST_ADDR) begin
                            sda_oe_q <= 1'b1;
                            bcast_q <= 1'b1;
                            phase_q <= PH_CTRL;
                        end else if (own_addr) begin
                            sda_oe_q <= 1'b1;
                            rd_idx_q <= 2'h0;
                            phase_q <= PH_READ;
                        end else begin
                            phase_q <= PH_IDLE;
                        end
                    end
                    PH_CTRL: begin
                        ctrl_q <= sh_q;
                        sda_oe_q <= 1'b1;
                        phase_q <= PH_HIGH;
                    end
                    PH_HIGH: begin
                        msb_q <= sh_q;
                        sda_oe_q <= 1'b1;
                        phase_q <= PH_LOW;
                    end
                    PH_LOW: begin
                        sda_oe_q <= 1'b1;
                        pend_q <= 1'b1;
                        phase_q <= PH_HIGH;
                    end
                    PH_READ: begin
                        sda_oe_q <= 1'b0;
                        rd_idx_q <= rd_idx_q + 2'h1;
                    end
                    default: begin
                        phase_q <= PH_IDLE;
                    end
                endcase
            end else if (phase_q == PH_READ) begin
                if (cnt_q == 4'h0 && (nack_q || rd_idx_q > rd_last)) begin
                    sda_oe_q <= 1'b0;
                    phase_q <= PH_IDLE;
                end else begin
                    sda_oe_q <= ~tx_byte[bit_idx];
                end
            end else if (cnt_q == 4'h0) begin
                sda_oe_q <= 1'b0;
                pend_q <= 1'b0;
                // Extended select mismatch drops the pair silently
                if (pend_q && ext_hit) begin
                    pay_q <= upd_new;
                    req_tgl_q <= ~req_tgl_q;
                    for (int i = 0; i < NUM_CH; i++) begin
                        if (upd_new.wr[i]) begin
                            rb_q[i] <= upd_new.word;
                        end
                    end
                end
            end
        end
    end

    assign o_sda_o = 1'b0;
    assign o_sda_oe = sda_oe_q;
    assign o_hs_mode = hs_q;

    // ****************************************
    // Crossing into the core clock
    // ****************************************
    // The payload holds still for at least 18 SCL cycles after each toggle,
    // far longer than the three core cycles needed to see the toggle.
    logic req_meta_q;
    logic req_sync_q;
    logic req_prev_q;
    logic ext_load_strobe_meta_q;
    logic ext_load_strobe_sync_q;
    logic ext_load_strobe_prev_q;
    logic upd_go;
    logic ext_load_strobe_go;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            req_meta_q <= 1'b0;
            req_sync_q <= 1'b0;
            req_prev_q <= 1'b0;
            ext_load_strobe_meta_q <= 1'b0;
            ext_load_strobe_sync_q <= 1'b0;
            ext_load_strobe_prev_q <= 1'b0;
        end else begin
            req_meta_q <= req_tgl_q;
            req_sync_q <= req_meta_q;
            req_prev_q <= req_sync_q;
            ext_load_strobe_meta_q <= i_ext_load_strobe;
            ext_load_strobe_sync_q <= ext_load_strobe_meta_q;
            ext_load_strobe_prev_q <= ext_load_strobe_sync_q;
        end
    end

    assign upd_go = req_sync_q ^ req_prev_q;
    assign ext_load_strobe_go = ext_load_strobe_sync_q & ~ext_load_strobe_prev_q;

    // ****************************************
    // Staging and output registers
    // ****************************************
    // The strobe edge is resampled, so outputs follow it two to three
    // core cycles later rather than truly asynchronously.
    logic [9:0] staging_reg_q [NUM_CH];
    logic [9:0] output_reg_q [NUM_CH];

    for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
        always_ff @(posedge i_core_clk or posedge i_rst) begin
            if (i_rst) begin
                staging_reg_q[ch] <= WORD_RST;
                output_reg_q[ch] <= WORD_RST;
            end else begin
                if (upd_go && pay_q.wr[ch]) begin
                    staging_reg_q[ch] <= pay_q.word;
                end
                if (upd_go && pay_q.ld[ch]) begin
                    output_reg_q[ch] <= pay_q.wr[ch] ? pay_q.word : staging_reg_q[ch];
                end else if (ext_load_strobe_go) begin
                    output_reg_q[ch] <= staging_reg_q[ch];
                end
            end
        end
    end

    assign o_out_ch_a = output_reg_q[0];
    assign o_out_ch_b = output_reg_q[1];
    assign o_out_ch_c = output_reg_q[2];
    assign o_out_ch_d = output_reg_q[3];

    // ****************************************
    // Assertions
    // ****************************************
    sequence s_low_byte;
        (phase_q == PH_LOW && cnt_q == ACK_BIT && !st_q && !sp_q) ##1 (cnt_q == 4'h0);
    endsequence

    a_update_at_ack: assert property (
        @(negedge i_scl) disable iff (i_rst)
        (s_low_byte ##0 (ext_hit && !st_q && !sp_q)) |=> (req_tgl_q != $past(req_tgl_q))
    ) else $error("update not issued after low byte ack");

    a_ack_data: assert property (
        @(negedge i_scl) disable iff (i_rst)
        (cnt_q == ACK_BIT && phase_q inside {PH_CTRL, PH_HIGH, PH_LOW} && !st_q && !sp_q)
        |=> sda_oe_q ##1 !sda_oe_q
    ) else $error("data byte ack not one clock long");

    a_low_ignored: assert property (
        @(negedge i_scl) disable iff (i_rst)
        (phase_q == PH_LOW && cnt_q == ACK_BIT) |=> $stable(msb_q)
    ) else $error("low byte altered stored high byte");

    a_hs_code_nack: assert property (
        @(negedge i_scl) disable iff (i_rst)
        (phase_q == PH_ADDR && cnt_q == ACK_BIT && sh_q[7:3] == HS_CODE && !st_q && !sp_q)
        |=> (!sda_oe_q && hs_q)
    ) else $error("master code acked or mode not set");

    a_bcast_read: assert property (
        @(negedge i_scl) disable iff (i_rst)
        (phase_q == PH_ADDR && cnt_q == ACK_BIT && sh_q == (BCAST_ADDR | 8'h01)
         && !st_q && !sp_q) |=> !sda_oe_q
    ) else $error("broadcast read acknowledged");

    a_addr_prefix: assert property (
        @(negedge i_scl) disable iff (i_rst)
        (phase_q == PH_ADDR && cnt_q == ACK_BIT && sh_q[7:3] != ADDR_PREFIX
         && sh_q != BCAST_ADDR && !st_q && !sp_q) |=> (!sda_oe_q && phase_q == PH_IDLE)
    ) else $error("foreign address accepted");

    a_stop_idle: assert property (
        @(negedge i_scl) disable iff (i_rst)
        sp_q |=> (phase_q inside {PH_IDLE, PH_ADDR} && !sda_oe_q && !hs_q)
    ) else $error("bus not released after stop");

    a_ext_load_strobe_copy: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        (ext_load_strobe_go && !upd_go) |=> output_reg_q[2] == $past(staging_reg_q[2])
    ) else $error("load strobe did not copy staging word");

    a_temp_only: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        (upd_go && pay_q.ld == MASK_NONE && !ext_load_strobe_go) |=> $stable(output_reg_q[1])
    ) else $error("staging-only write moved an output");

    a_dac_load: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        (upd_go && pay_q.wr[0] && pay_q.ld[0])
        |=> (output_reg_q[0] == $past(pay_q.word) && staging_reg_q[0] == $past(pay_q.word))
    ) else $error("selected output not loaded with new word");

endmodule

/* File: bench/i2c_master_model.sv */
// Serial bus master model for the quad DAC update logic.
// Assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/10ps
module i2c_master_model (
    // Resolved data line
    input wire logic i_sda,
    // Bus drive
    output logic o_scl,
    output logic o_sda_low
);
    // ****************************************
    // Conditions and bytes, 64 ns bit period
    // ****************************************
    initial begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end

    // Also a repeated start; the clock only moves inside frames
    task automatic start_cond();
        o_sda_low = 1'b0;
        #16 o_scl = 1'b1;
        #16 o_sda_low = 1'b1;
        #16 o_scl = 1'b0;
        #16;
    endtask

    task automatic stop_cond();
        o_sda_low = 1'b1;
        #16 o_scl = 1'b1;
        #16 o_sda_low = 1'b0;
        #16;
    endtask

    // Data changes only while the clock is low
    task automatic bit_out(input logic b);
        o_sda_low = ~b;
        #16 o_scl = 1'b1;
        #32 o_scl = 1'b0;
        #16;
    endtask

    // Nine clocks per byte, so a byte pair takes eighteen
    task automatic write_byte(input logic [7:0] d, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_out(d[i]);
        end
        o_sda_low = 1'b0;
        #16 o_scl = 1'b1;
        #16 ack = (i_sda === 1'b0);
        #16 o_scl = 1'b0;
        #16;
    endtask

    task automatic read_byte(input logic nack, output logic [7:0] d);
        o_sda_low = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            #16 o_scl = 1'b1;
            #16 d[i] = i_sda;
            #16 o_scl = 1'b0;
            #16;
        end
        bit_out(nack);
    endtask
endmodule

/* File: bench/quad_dac_i2c_update_logic_tb_top.sv */
// Self-checking bench for the quad DAC serial update logic.
// Assumes device straps 10, extended pins 01, so own write address 9c.
`timescale 1ns/10ps
module quad_dac_i2c_update_logic_tb_top;
    // ****************************************
    // Clock, wire and design
    // ****************************************
    localparam logic [7:0] ADW = 8'h9c;
    localparam logic [7:0] ADR = 8'h9d;
    logic i_core_clk = 1'b0;
    logic i_rst;
    logic strobe = 1'b0;
    logic scl, sda_low, sda, sda_o, sda_oe, hs;
    logic [9:0] out_a, out_b, out_c, out_d;
    int n_mismatch = 0;
    int comparisons = 0;
    int cycles = 0;

    always #20 i_core_clk = ~i_core_clk;
    assign sda = !(sda_low || (sda_oe && !sda_o));

    i2c_master_model m (.i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));

    quad_dac_update dut (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_scl(scl),
        .i_sda(sda),
        .o_sda_o(sda_o),
        .o_sda_oe(sda_oe),
        .o_hs_mode(hs),
        .i_dev_select_hi(1'b1),
        .i_dev_select_lo(1'b0),
        .i_ext_select_hi(1'b0),
        .i_ext_select_lo(1'b1),
        .i_ext_load_strobe(strobe),
        .o_out_ch_a(out_a),
        .o_out_ch_b(out_b),
        .o_out_ch_c(out_c),
        .o_out_ch_d(out_d)
    );

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // A hang ends the run here
    always @(posedge i_core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            give_verdict();
        end
    end

    task automatic check(input string nm, input logic [9:0] seen, input logic [9:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic outs(input logic [9:0] a, input logic [9:0] b, input logic [9:0] c,
                        input logic [9:0] d);
        check("channel a", out_a, a);
        check("channel b", out_b, b);
        check("channel c", out_c, c);
        check("channel d", out_d, d);
    endtask

    // Low bytes are all-ones junk so that using them would show
    task automatic xfer(input logic [7:0] adr, input logic [7:0] ctl,
                        input logic [15:0] his, input int n);
        logic a;
        m.start_cond();
        m.write_byte(adr, a);
        check("ack address", {9'h0, a}, 10'h1);
        m.write_byte(ctl, a);
        check("ack control", {9'h0, a}, 10'h1);
        for (int i = 0; i < n; i++) begin
            m.write_byte(i[0] ? 8'hff : his[15 - 8 * (i / 2) -: 8], a);
            check("ack data", {9'h0, a}, 10'h1);
        end
        m.stop_cond();
        repeat (4) @(posedge i_core_clk);
    endtask

    task automatic rd(input logic [7:0] ctl, input int n, input logic [23:0] exp);
        logic a;
        logic [7:0] d;
        m.start_cond();
        m.write_byte(ADW, a);
        m.write_byte(ctl, a);
        m.start_cond();
        m.write_byte(ADR, a);
        check("ack read address", {9'h0, a}, 10'h1);
        for (int i = 0; i < n; i++) begin
            m.read_byte(i == n - 1, d);
            check("read byte", {2'h0, d}, {2'h0, exp[8 * (n - 1 - i) +: 8]});
        end
        m.stop_cond();
    endtask

    task automatic refuse(input logic [7:0] adr);
        logic a;
        m.start_cond();
        m.write_byte(adr, a);
        check("no ack", {9'h0, a}, 10'h0);
        m.stop_cond();
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic scn_reset_read();
        outs(10'h0, 10'h0, 10'h0, 10'h0);
        rd(8'h40, 2, 24'h0);
    endtask

    task automatic scn_single_and_strobe();
        xfer(ADW, 8'h52, 16'ha500, 2);
        outs(10'h0, 10'ha5, 10'h0, 10'h0);
        xfer(ADW, 8'h44, 16'h3c00, 2);
        outs(10'h0, 10'ha5, 10'h0, 10'h0);
        @(posedge i_core_clk);
        strobe <= 1'b1;
        repeat (6) @(posedge i_core_clk);
        strobe <= 1'b0;
        repeat (2) @(posedge i_core_clk);
        outs(10'h0, 10'ha5, 10'h3c, 10'h0);
    endtask

    task automatic scn_pairs();
        xfer(ADW, 8'h50, 16'h1122, 4);
        outs(10'h22, 10'ha5, 10'h3c, 10'h0);
        xfer(ADW, 8'h50, 16'h4433, 3);
        outs(10'h44, 10'ha5, 10'h3c, 10'h0);
    endtask

    task automatic scn_sync_modes();
        xfer(ADW, 8'h46, 16'h7700, 2);
        xfer(ADW, 8'h42, 16'h1200, 2);
        outs(10'h44, 10'ha5, 10'h3c, 10'h0);
        xfer(ADW, 8'h60, 16'h6600, 2);
        outs(10'h66, 10'h12, 10'h3c, 10'h77);
        xfer(ADW, 8'h44, 16'h5a00, 2);
        xfer(ADW, 8'h70, 16'hff00, 2);
        outs(10'h66, 10'h12, 10'h5a, 10'h77);
    endtask

    // Extended bits deliberately wrong; broadcast must not care
    task automatic scn_broadcast_pd();
        xfer(8'h90, 8'hb5, 16'h8000, 2);
        outs(10'h200, 10'h200, 10'h200, 10'h200);
        xfer(ADW, 8'h10, 16'h9900, 2);
        outs(10'h200, 10'h200, 10'h200, 10'h200);
        xfer(ADW, 8'h45, 16'h4000, 2);
        rd(8'h45, 3, 24'h7f0000);
    endtask

    task automatic scn_refusals();
        refuse(8'h94);
        refuse(8'h1c);
        refuse(8'h91);
        refuse(8'h08);
        check("hs mode set", {9'h0, hs}, 10'h1);
        xfer(ADW, 8'h56, 16'h3300, 2);
        check("channel d", out_d, 10'h33);
        check("hs mode clear", {9'h0, hs}, 10'h0);
    endtask

    initial begin
        // Raised here, not at declaration, so the asynchronous reset sees an edge
        i_rst <= 1'b1;
        repeat (20) @(posedge i_core_clk);
        i_rst <= 1'b0;
        repeat (2) @(posedge i_core_clk);
        scn_reset_read();
        scn_single_and_strobe();
        scn_pairs();
        scn_sync_modes();
        scn_broadcast_pd();
        scn_refusals();
        give_verdict();
    end
endmodule
